// ===== pkg/sxe_pkg.sv
// Purpose: Shared constants and types for the subtract/exclusive-OR execute block.
// Assumes: 16-bit instruction words, 4-bit data, 7-bit data memory addresses.
// Notes:   Working registers occupy the lowest sixteen data memory locations.
`default_nettype none

package sxe_pkg;

  localparam int DATA_W    = 4;
  localparam int ADDR_W    = 7;
  localparam int INSTR_W   = 16;
  localparam int MEM_DEPTH = 128;

  // Opcode field positions and values.
  localparam int            OP8_LSB     = 8;
  localparam int            OP9_LSB     = 7;
  localparam int            IMM_LSB     = 4;
  localparam int            WSEL_LSB    = 0;
  localparam int            MADDR_LSB   = 0;
  localparam int            WSEL_W      = 4;
  localparam logic [7:0]    OP_SUBTRACT_WRITEBACK_OP_WR  = 8'h1f;
  localparam logic [7:0]    OP_XRL_WR   = 8'h3c;
  localparam logic [7:0]    OP_XOR_WRITEBACK_OP_WR  = 8'h3d;
  localparam logic [8:0]    OP_XRL_MEM  = 9'h070;
  localparam logic [8:0]    OP_XOR_WRITEBACK_OP_MEM = 9'h072;
  localparam logic [2:0]    WR_BASE_HI  = 3'h0;

  // Reset values.
  localparam logic [3:0]    ACC_RST     = 4'h0;
  localparam logic          CF_RST      = 1'b0;
  localparam logic          ZF_RST      = 1'b0;
  localparam logic [3:0]    RD_RST      = 4'h0;

  typedef enum logic [2:0] {
    SXE_OP_NONE,
    SXE_OP_SUBTRACT_WRITEBACK_OP_WR,
    SXE_OP_XRL_MEM,
    SXE_OP_XRL_WR,
    SXE_OP_XOR_WRITEBACK_OP_MEM,
    SXE_OP_XOR_WRITEBACK_OP_WR
  } sxe_op_t;

endpackage : sxe_pkg

`default_nettype wire

// ===== rtl/sxe_exec.sv
// Purpose: One-cycle decode and execute of subtract-immediate-with-writeback and the
//          exclusive-OR group, with accumulator, flags and the 128 x 4 data memory.
// Assumes: instrValid is a one-cycle pulse from fetch logic on the same clock.
// Notes:   Carry holds the borrow of the subtraction (1 when immediate exceeds WR).
`timescale 1ns/10ps
`default_nettype none

module sxe_exec
  import sxe_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               instrValid,
  input  wire logic [INSTR_W-1:0] instrWord,
  input  wire logic               loadEn,
  input  wire logic [ADDR_W-1:0]  loadAddr,
  input  wire logic [DATA_W-1:0]  loadData,
  input  wire logic               accLoadEn,
  input  wire logic [DATA_W-1:0]  accLoadData,
  input  wire logic [ADDR_W-1:0]  memRdAddr,
  output logic      [DATA_W-1:0]  memRdData,
  output logic      [DATA_W-1:0]  accumulator,
  output logic                    carryFlag,
  output logic                    zeroFlag,
  output logic                    execDone
);

  logic [DATA_W-1:0] memArr [MEM_DEPTH];
  logic [DATA_W-1:0] accumulator_ff;
  logic              carryFlag_ff;
  logic              zeroFlag_ff;
  logic              execDone_ff;
  logic [DATA_W-1:0] memRdData_ff;

  sxe_op_t           opKind;
  logic [DATA_W-1:0] immVal;
  logic [ADDR_W-1:0] wrAddr;
  logic [ADDR_W-1:0] memAddr;
  logic [ADDR_W-1:0] srcAddr;
  logic [DATA_W-1:0] srcVal;
  logic [DATA_W:0]   subWide;
  logic [DATA_W-1:0] subDiff;
  logic              subBorrow;
  logic [DATA_W-1:0] xorImm;
  logic [DATA_W-1:0] xorMem;
  logic [DATA_W-1:0] nxt_acc;
  logic              nxt_zero;
  logic              resWrite;
  logic              memLoadHit;

  assign immVal  = instrWord[IMM_LSB +: DATA_W];
  assign wrAddr  = {WR_BASE_HI, instrWord[WSEL_LSB +: WSEL_W]};
  assign memAddr = instrWord[MADDR_LSB +: ADDR_W];
  // Flags an external load to the nibble that a memory-form instruction reads.
  assign memLoadHit = loadEn && (loadAddr == memAddr);

  // Decode; only a valid instruction selects an operation.
  always_comb begin
    opKind = SXE_OP_NONE;
    if (instrValid) begin
      if (instrWord[OP8_LSB +: 8] == OP_SUBTRACT_WRITEBACK_OP_WR) begin
        opKind = SXE_OP_SUBTRACT_WRITEBACK_OP_WR;
      end else if (instrWord[OP8_LSB +: 8] == OP_XRL_WR) begin
        opKind = SXE_OP_XRL_WR;
      end else if (instrWord[OP8_LSB +: 8] == OP_XOR_WRITEBACK_OP_WR) begin
        opKind = SXE_OP_XOR_WRITEBACK_OP_WR;
      end else if (instrWord[OP9_LSB +: 9] == OP_XRL_MEM) begin
        opKind = SXE_OP_XRL_MEM;
      end else if (instrWord[OP9_LSB +: 9] == OP_XOR_WRITEBACK_OP_MEM) begin
        opKind = SXE_OP_XOR_WRITEBACK_OP_MEM;
      end
    end
  end

  // Register-immediate forms read the working register, memory forms the addressed nibble.
  assign srcAddr   = (opKind == SXE_OP_XRL_MEM || opKind == SXE_OP_XOR_WRITEBACK_OP_MEM) ? memAddr : wrAddr;
  assign srcVal    = memArr[srcAddr];
  assign subWide   = {1'b0, srcVal} - {1'b0, immVal};
  assign subDiff   = subWide[DATA_W-1:0];
  assign subBorrow = subWide[DATA_W];
  assign xorImm    = srcVal ^ immVal;
  assign xorMem    = srcVal ^ accumulator_ff;

  always_comb begin
    nxt_acc  = accumulator_ff;
    resWrite = 1'b0;
    case (opKind)
      SXE_OP_SUBTRACT_WRITEBACK_OP_WR: begin
        nxt_acc  = subDiff;
        resWrite = 1'b1;
      end
      SXE_OP_XRL_WR: begin
        nxt_acc = xorImm;
      end
      SXE_OP_XOR_WRITEBACK_OP_WR: begin
        nxt_acc  = xorImm;
        resWrite = 1'b1;
      end
      SXE_OP_XRL_MEM: begin
        nxt_acc = xorMem;
      end
      SXE_OP_XOR_WRITEBACK_OP_MEM: begin
        nxt_acc  = xorMem;
        resWrite = 1'b1;
      end
      default: begin
        nxt_acc  = accumulator_ff;
        resWrite = 1'b0;
      end
    endcase
  end

  assign nxt_zero = (nxt_acc == '0);

  // Accumulator: an executing instruction takes priority over a direct load.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      accumulator_ff <= ACC_RST;
    end else if (opKind != SXE_OP_NONE) begin
      accumulator_ff <= nxt_acc;
    end else if (accLoadEn) begin
      accumulator_ff <= accLoadData;
    end
  end

  // Carry changes only on the subtract.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      carryFlag_ff <= CF_RST;
    end else if (opKind == SXE_OP_SUBTRACT_WRITEBACK_OP_WR) begin
      carryFlag_ff <= subBorrow;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      zeroFlag_ff <= ZF_RST;
    end else if (opKind != SXE_OP_NONE) begin
      zeroFlag_ff <= nxt_zero;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      execDone_ff <= 1'b0;
    end else begin
      execDone_ff <= (opKind != SXE_OP_NONE);
    end
  end

  // Data memory holds no reset; writeback wins over an external load in the same cycle.
  always_ff @(posedge clk) begin
    if (resWrite) begin
      memArr[srcAddr] <= nxt_acc;
    end else if (loadEn) begin
      memArr[loadAddr] <= loadData;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      memRdData_ff <= RD_RST;
    end else begin
      memRdData_ff <= memArr[memRdAddr];
    end
  end

  assign accumulator = accumulator_ff;
  assign carryFlag   = carryFlag_ff;
  assign zeroFlag    = zeroFlag_ff;
  assign execDone    = execDone_ff;
  assign memRdData   = memRdData_ff;

  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_subrIssued;
    opKind == SXE_OP_SUBTRACT_WRITEBACK_OP_WR;
  endsequence

  sequence s_subrDone;
    execDone && accumulator == $past(subDiff) && carryFlag == $past(subBorrow);
  endsequence

  property p_subtract_writeback_op_result;
    s_subrIssued |=> s_subrDone ##0 (zeroFlag == (accumulator == '0));
  endproperty
  a_subtract_writeback_op_result: assert property (p_subtract_writeback_op_result) else $error("subtract result wrong");

  property p_subtract_writeback_op_wb;
    s_subrIssued |=> memArr[$past(wrAddr)] == accumulator;
  endproperty
  a_subtract_writeback_op_wb: assert property (p_subtract_writeback_op_wb) else $error("subtract writeback wrong");

  property p_xrl_mem;
    opKind == SXE_OP_XRL_MEM |=> accumulator == $past(xorMem) && $stable(carryFlag)
      && zeroFlag == (accumulator == '0)
      && memArr[$past(memAddr)] == ($past(memLoadHit) ? $past(loadData) : $past(srcVal));
  endproperty
  a_xrl_mem: assert property (p_xrl_mem) else $error("xor memory to acc wrong");

  property p_xrl_wr;
    opKind == SXE_OP_XRL_WR |=> accumulator == $past(xorImm) && $stable(carryFlag)
      && zeroFlag == (accumulator == '0);
  endproperty
  a_xrl_wr: assert property (p_xrl_wr) else $error("xor immediate to acc wrong");

  property p_xor_writeback_op_mem;
    opKind == SXE_OP_XOR_WRITEBACK_OP_MEM |=> accumulator == $past(xorMem)
      && memArr[$past(memAddr)] == accumulator && $stable(carryFlag)
      && zeroFlag == (accumulator == '0);
  endproperty
  a_xor_writeback_op_mem: assert property (p_xor_writeback_op_mem) else $error("xor memory writeback wrong");

  property p_xor_writeback_op_wr;
    opKind == SXE_OP_XOR_WRITEBACK_OP_WR |=> accumulator == $past(xorImm)
      && memArr[$past(wrAddr)] == accumulator && $stable(carryFlag)
      && zeroFlag == (accumulator == '0);
  endproperty
  a_xor_writeback_op_wr: assert property (p_xor_writeback_op_wr) else $error("xor immediate writeback wrong");

  property p_idle_hold;
    !instrValid && !accLoadEn |=> $stable(accumulator) && $stable(zeroFlag) && !execDone;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("state moved while idle");

  property p_done_one;
    execDone ##1 !instrValid |=> !execDone;
  endproperty
  a_done_one: assert property (p_done_one) else $error("done held too long");

endmodule : sxe_exec

`default_nettype wire

// ===== tb/tb_sxe_exec.sv
// Purpose: Self-checking bench for the subtract/exclusive-OR execute block.
// Assumes: Inputs change 1 ns after the rising edge; results are read one cycle later.
// Notes:   A shadow memory and accumulator model predict every result.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp=%h got=%h", nm, e, g); end end

module tb_sxe_exec;
  import sxe_pkg::*;
  logic        clk, resetn, instrValid, loadEn, accLoadEn;
  logic [15:0] instrWord;
  logic [6:0]  loadAddr, memRdAddr;
  logic [3:0]  loadData, accLoadData, memRdData, accumulator;
  logic        carryFlag, zeroFlag, execDone;
  logic [3:0]  mem [128];
  logic [3:0]  eAcc;
  logic        eCf, eZf, eDone;
  int          errors, n_checks, seed;
  logic [31:0] r;

  sxe_exec uut (.clk(clk), .resetn(resetn), .instrValid(instrValid), .instrWord(instrWord),
    .loadEn(loadEn), .loadAddr(loadAddr), .loadData(loadData), .accLoadEn(accLoadEn),
    .accLoadData(accLoadData), .memRdAddr(memRdAddr), .memRdData(memRdData),
    .accumulator(accumulator), .carryFlag(carryFlag), .zeroFlag(zeroFlag),
    .execDone(execDone));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // Predicts the state after one edge; memory is read before any write lands.
  function automatic void model(input logic [15:0] w, input logic le, input logic [6:0] la,
                                input logic [3:0] ld, input logic ae, input logic [3:0] ad);
    logic [3:0] wr, res;
    logic       wb, ok;
    logic [6:0] dst;
    wr = mem[w[3:0]];
    ok = 1'b1;
    wb = 1'b0;
    dst = {3'h0, w[3:0]};
    if (w[15:8] == OP_SUBTRACT_WRITEBACK_OP_WR) begin
      res = wr - w[7:4];
      eCf = (w[7:4] > wr);
      wb = 1'b1;
    end else if (w[15:8] == OP_XRL_WR) res = wr ^ w[7:4];
    else if (w[15:8] == OP_XOR_WRITEBACK_OP_WR) begin
      res = wr ^ w[7:4];
      wb = 1'b1;
    end else if (w[15:7] == OP_XRL_MEM) res = mem[w[6:0]] ^ eAcc;
    else if (w[15:7] == OP_XOR_WRITEBACK_OP_MEM) begin
      res = mem[w[6:0]] ^ eAcc;
      wb = 1'b1;
      dst = w[6:0];
    end else ok = 1'b0;
    eDone = ok;
    if (ok) begin
      eAcc = res;
      eZf = (res == 4'h0);
    end else if (ae) eAcc = ad;
    if (le && !wb) mem[la] = ld;
    if (wb) mem[dst] = res;
  endfunction : model

  task automatic step(input logic [15:0] w, input logic le, input logic [6:0] la,
                      input logic [3:0] ld, input logic ae, input logic [3:0] ad);
    instrValid = 1'b1;
    instrWord = w;
    loadEn = le;
    loadAddr = la;
    loadData = ld;
    accLoadEn = ae;
    accLoadData = ad;
    model(w, le, la, ld, ae, ad);
    @(posedge clk);
    #1;
    `CHK("accumulator", eAcc, accumulator)
    `CHK("carryFlag", eCf, carryFlag)
    `CHK("zeroFlag", eZf, zeroFlag)
    `CHK("execDone", eDone, execDone)
  endtask : step

  task automatic idle_and_sweep();
    instrValid = 1'b0;
    loadEn = 1'b0;
    accLoadEn = 1'b0;
    for (int a = 0; a < 128; a++) begin
      memRdAddr = a[6:0];
      @(posedge clk);
      #1;
      `CHK("memRdData", mem[a], memRdData)
      `CHK("idle accumulator", eAcc, accumulator)
      `CHK("idle execDone", 1'b0, execDone)
    end
  endtask : idle_and_sweep

  initial begin
    {instrValid, loadEn, accLoadEn, resetn} = 4'h0;
    {instrWord, loadAddr, loadData, accLoadData, memRdAddr} = '0;
    errors = 0;
    n_checks = 0;
    seed = 32'h011a;
    {eAcc, eCf, eZf, eDone} = {ACC_RST, CF_RST, ZF_RST, 1'b0};
    repeat (20) @(posedge clk);
    #1;
    `CHK("reset state", 8'h00, {accumulator, carryFlag, zeroFlag, execDone, memRdData[0]})
    resetn = 1'b1;
    for (int a = 0; a < 128; a++) step(16'h0000, 1'b1, a[6:0], 4'($random(seed)), 1'b0, 4'h0);
    $display("test reset and load done");
    step(16'h0000, 1'b1, 7'h05, 4'h3, 1'b1, 4'h6);
    step(16'h1f35, 1'b0, 7'h00, 4'h0, 1'b0, 4'h0);
    `CHK("equal subtract", 6'h01, {accumulator, carryFlag, zeroFlag})
    step(16'h1f75, 1'b1, 7'h05, 4'hf, 1'b1, 4'ha);
    `CHK("borrow subtract", 6'h26, {accumulator, carryFlag, zeroFlag})
    step(16'h3c95, 1'b0, 7'h00, 4'h0, 1'b0, 4'h0);
    `CHK("xor to zero", 6'h03, {accumulator, carryFlag, zeroFlag})
    step(16'h387f, 1'b1, 7'h7f, 4'h1, 1'b0, 4'h0);
    step(16'h3900, 1'b1, 7'h00, 4'h2, 1'b0, 4'h0);
    step(16'h3da5, 1'b0, 7'h00, 4'h0, 1'b1, 4'h4);
    idle_and_sweep();
    $display("test corner cases done");
    @(posedge clk);
    #1;
    for (int i = 0; i < 400; i++) begin
      r = $random(seed);
      case (r[18:16])
        3'h0: r[15:8] = OP_SUBTRACT_WRITEBACK_OP_WR;
        3'h1: r[15:8] = OP_XRL_WR;
        3'h2: r[15:8] = OP_XOR_WRITEBACK_OP_WR;
        3'h3: r[15:7] = OP_XRL_MEM;
        3'h4: r[15:7] = OP_XOR_WRITEBACK_OP_MEM;
        default: ;
      endcase
      step(r[15:0], r[20:19] == 2'h0, r[27:21], r[31:28], r[23:22] == 2'h0, r[19:16]);
    end
    idle_and_sweep();
    $display("test random stream done");
    tally_and_finish();
  end

  initial begin
    #20000;
    errors++;
    $display("BAD watchdog exp=%h got=%h", 1'b0, 1'b1);
    tally_and_finish();
  end
endmodule : tb_sxe_exec
`default_nettype wire
